// ---- src/led_pattern_defs.svh ----
`ifndef LED_PATTERN_DEFS_SVH
`define LED_PATTERN_DEFS_SVH

// ****************************************************************
// time base
// ****************************************************************
`define CLK_HZ 200000000
`define QUARTER_MS 250
`define TICK_CYCLES ((`CLK_HZ / 1000) * `QUARTER_MS)
`define WEAK_MS 5000
`define WEAK_CYCLES ((`CLK_HZ / 1000) * `WEAK_MS)

// ****************************************************************
// pattern timing in quarter seconds
// ****************************************************************
`define BLINK_HALF_Q 8'h02
`define PULSE_ON_Q 8'h01
`define PULSE_PERIOD_Q 8'h10
`define FLASH_HALF_Q 8'h01
`define GAP_Q 8'h04
`define PAUSE_Q 8'h0C
`define BUS_FLASH_Q 8'h01

// ****************************************************************
// fault counts
// ****************************************************************
`define CNT_PS_OPEN 4'h2
`define CNT_PS_CLOSED 4'h3
`define CNT_PS_DROP 4'h4
`define CNT_LOW_FLAME_X 4'h1
`define CNT_LOW_FLAME_Y 4'h2

// ****************************************************************
// dim pwm
// ****************************************************************
`define PWM_BITS 16
`define DIM_DUTY 16'h2000

`endif

// ---- src/led_pattern_pkg.sv ----
package led_pattern_pkg;
   typedef enum logic [2:0] {
      pat_off, pat_blink, pat_pulse, pat_heart, pat_count, pat_two
   } pat_type;
   typedef enum logic [2:0] {
      seq_first, seq_gap, seq_second, seq_pause, seq_run
   } seq_type;
endpackage

// ---- src/status_led_pattern_generator.sv ----
// Function
// - blink: half second on, half off
// - pulse: quarter on, 3.75 s off
// - heartbeat: half bright, half dim, alternating
// - X flashes at 2 Hz, 3 s off
// - X flashes, 1 s, Y flashes, 3 s
// - flame LED off otherwise
// - flame LED heartbeat: heat and flame
// - flame LED blinks on weak flame
// - flame LED heartbeat: out-of-sequence flame present during a heat call (off without heat call)
// - history recall shows weak flame 1+2
// - status LED pulses in standby
// - status LED heartbeat in normal heat
// - status LED two flashes: switch open
// - status LED three flashes: switch closed
// - status LED four flashes: switch dropped
// - bus LED flashes rapidly while transmitting
// - bus LED single blink on acknowledged receive
// - bus LED active regardless of thermostat type
// - weak flame raised/cleared after five seconds
`timescale 1ns/1ps
`include "led_pattern_defs.svh"

module status_led_pattern_generator #(
   parameter int TICK_CYCLES = `TICK_CYCLES,
   parameter int WEAK_CYCLES = `WEAK_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // controller conditions
   input wire logic heat_call,
   input wire logic flame_present,
   input wire logic flame_weak,
   input wire logic normal_fire,
   input wire logic flame_out_of_seq,
   input wire logic history_recall,
   input wire logic ps_failed_open,
   input wire logic ps_failed_closed,
   input wire logic ps_opened_run,
   // bus activity
   input wire logic bus_tx_active,
   input wire logic bus_rx_ack,
   // leds
   output logic flame_led,
   output logic status_led,
   output logic bus_activity_led,
   output logic weak_flame_flag
);
   import led_pattern_pkg::*;

   // ****************************************************************
   // quarter-second tick and dim pwm
   // ****************************************************************
   logic [31:0] tick_cnt_ff, nxt_tick_cnt;
   logic tick;
   logic [`PWM_BITS-1:0] pwm_ff, nxt_pwm;
   logic dim_on;

   always_comb begin
      tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1));
      nxt_tick_cnt = tick ? 32'h0 : tick_cnt_ff + 32'h1;
      nxt_pwm = pwm_ff + `PWM_BITS'(1);
      dim_on = (pwm_ff < `DIM_DUTY);
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         tick_cnt_ff <= 32'h0;
         pwm_ff <= '0;
      end else begin
         tick_cnt_ff <= nxt_tick_cnt;
         pwm_ff <= nxt_pwm;
      end
   end

   // ****************************************************************
   // weak flame qualification
   // ****************************************************************
   logic [31:0] weak_cnt_ff, nxt_weak_cnt;
   logic weak_ff, nxt_weak;

   always_comb begin
      nxt_weak = weak_ff;
      nxt_weak_cnt = 32'h0;
      if (!heat_call) begin
         nxt_weak = 1'b0;
      end else if (!weak_ff) begin
         if (flame_weak && normal_fire) begin
            nxt_weak_cnt = weak_cnt_ff + 32'h1;
            if (weak_cnt_ff >= 32'(WEAK_CYCLES)) begin
               nxt_weak = 1'b1;
            end
         end
      end else if (flame_present && !flame_weak) begin
         nxt_weak_cnt = weak_cnt_ff + 32'h1;
         if (weak_cnt_ff >= 32'(WEAK_CYCLES)) begin
            nxt_weak = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         weak_cnt_ff <= 32'h0;
         weak_ff <= 1'b0;
      end else begin
         weak_cnt_ff <= nxt_weak_cnt;
         weak_ff <= nxt_weak;
      end
   end

   assign weak_flame_flag = weak_ff;

   // ****************************************************************
   // pattern selection
   // ****************************************************************
   pat_type flame_pat, status_pat;
   logic [3:0] flame_x, flame_y, status_x;

   always_comb begin
      flame_pat = pat_off;
      flame_x = 4'h0;
      flame_y = 4'h0;
      if (history_recall && weak_ff) begin
         flame_pat = pat_two;
         flame_x = `CNT_LOW_FLAME_X;
         flame_y = `CNT_LOW_FLAME_Y;
      end else if (heat_call && weak_ff) begin
         flame_pat = pat_blink;
      end else if (heat_call && flame_present && flame_out_of_seq) begin
         flame_pat = pat_heart;
      end else if (heat_call && flame_present) begin
         flame_pat = pat_heart;
      end
   end

   always_comb begin
      status_x = 4'h0;
      if (ps_failed_open) begin
         status_pat = pat_count;
         status_x = `CNT_PS_OPEN;
      end else if (ps_failed_closed) begin
         status_pat = pat_count;
         status_x = `CNT_PS_CLOSED;
      end else if (ps_opened_run) begin
         status_pat = pat_count;
         status_x = `CNT_PS_DROP;
      end else if (heat_call) begin
         status_pat = pat_heart;
      end else begin
         status_pat = pat_pulse;
      end
   end

   // ****************************************************************
   // pattern sequencers
   // ****************************************************************
   pat_type cur_pat_ff [2], nxt_cur_pat [2];
   logic [3:0] cur_x_ff [2], nxt_cur_x [2];
   seq_type st_ff [2], nxt_st [2];
   logic [7:0] q_ff [2], nxt_q [2];
   logic [3:0] n_ff [2], nxt_n [2];
   logic bright [2], lit_ff [2], nxt_lit [2];
   pat_type sel_pat [2];
   logic [3:0] sel_x [2], sel_y [2];

   always_comb begin
      sel_pat[0] = flame_pat;
      sel_x[0] = flame_x;
      sel_y[0] = flame_y;
      sel_pat[1] = status_pat;
      sel_x[1] = status_x;
      sel_y[1] = 4'h0;
   end

   for (genvar i = 0; i < 2; i++) begin : g_seq
      always_comb begin
         nxt_cur_pat[i] = sel_pat[i];
         nxt_cur_x[i] = sel_x[i];
         nxt_st[i] = st_ff[i];
         nxt_q[i] = q_ff[i];
         nxt_n[i] = n_ff[i];
         bright[i] = 1'b0;
         if (sel_pat[i] != cur_pat_ff[i] || sel_x[i] != cur_x_ff[i]) begin
            nxt_q[i] = 8'h0;
            nxt_n[i] = 4'h0;
            nxt_st[i] = (sel_pat[i] == pat_count || sel_pat[i] == pat_two)
               ? seq_first : seq_run;
         end else if (tick) begin
            nxt_q[i] = q_ff[i] + 8'h1;
            unique case (st_ff[i])
               seq_run: begin
                  if (cur_pat_ff[i] == pat_pulse &&
                      q_ff[i] == `PULSE_PERIOD_Q - 8'h1) begin
                     nxt_q[i] = 8'h0;
                  end else if (cur_pat_ff[i] != pat_pulse &&
                      q_ff[i] == 8'h2 * `BLINK_HALF_Q - 8'h1) begin
                     nxt_q[i] = 8'h0;
                  end
               end
               seq_first, seq_second: begin
                  if (q_ff[i] == 8'h2 * `FLASH_HALF_Q - 8'h1) begin
                     nxt_q[i] = 8'h0;
                     nxt_n[i] = n_ff[i] + 4'h1;
                     if (n_ff[i] + 4'h1 ==
                         (st_ff[i] == seq_first ? cur_x_ff[i] : sel_y[i])) begin
                        nxt_n[i] = 4'h0;
                        nxt_st[i] = (st_ff[i] == seq_first &&
                           cur_pat_ff[i] == pat_two) ? seq_gap : seq_pause;
                     end
                  end
               end
               seq_gap: begin
                  if (q_ff[i] == `GAP_Q - 8'h1) begin
                     nxt_q[i] = 8'h0;
                     nxt_st[i] = seq_second;
                  end
               end
               seq_pause: begin
                  if (q_ff[i] == `PAUSE_Q - 8'h1) begin
                     nxt_q[i] = 8'h0;
                     nxt_st[i] = seq_first;
                  end
               end
               default: nxt_st[i] = seq_run;
            endcase
         end
         unique case (cur_pat_ff[i])
            pat_blink: bright[i] = (q_ff[i] < `BLINK_HALF_Q);
            pat_pulse: bright[i] = (q_ff[i] < `PULSE_ON_Q);
            pat_heart: bright[i] = (q_ff[i] < `BLINK_HALF_Q) || dim_on;
            pat_count, pat_two: bright[i] =
               (st_ff[i] == seq_first || st_ff[i] == seq_second) &&
               (q_ff[i] < `FLASH_HALF_Q);
            default: bright[i] = 1'b0;
         endcase
         nxt_lit[i] = bright[i];
      end

      always_ff @(posedge clk) begin
         if (!nrst) begin
            cur_pat_ff[i] <= pat_off;
            cur_x_ff[i] <= 4'h0;
            st_ff[i] <= seq_run;
            q_ff[i] <= 8'h0;
            n_ff[i] <= 4'h0;
            lit_ff[i] <= 1'b0;
         end else begin
            cur_pat_ff[i] <= nxt_cur_pat[i];
            cur_x_ff[i] <= nxt_cur_x[i];
            st_ff[i] <= nxt_st[i];
            q_ff[i] <= nxt_q[i];
            n_ff[i] <= nxt_n[i];
            lit_ff[i] <= nxt_lit[i];
         end
      end
   end

   assign flame_led = lit_ff[0];
   assign status_led = lit_ff[1];

   // ****************************************************************
   // bus activity led
   // ****************************************************************
   logic [7:0] bus_q_ff, nxt_bus_q;
   logic blink_ff, nxt_blink;
   logic bus_led_ff, nxt_bus_led;

   always_comb begin
      nxt_bus_q = bus_q_ff;
      nxt_blink = blink_ff;
      if (bus_rx_ack) begin
         nxt_blink = 1'b1;
         nxt_bus_q = 8'h0;
      end else if (tick && (blink_ff || bus_tx_active)) begin
         nxt_bus_q = bus_q_ff + 8'h1;
         if (bus_q_ff == `BUS_FLASH_Q - 8'h1) begin
            nxt_blink = 1'b0;
         end
      end
      // visible toggle each quarter second while sending, any thermostat
      nxt_bus_led = (bus_tx_active && bus_q_ff[0]) ||
         (!bus_tx_active && blink_ff);
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         bus_q_ff <= 8'h0;
         blink_ff <= 1'b0;
         bus_led_ff <= 1'b0;
      end else begin
         bus_q_ff <= nxt_bus_q;
         blink_ff <= nxt_blink;
         bus_led_ff <= nxt_bus_led;
      end
   end

   assign bus_activity_led = bus_led_ff;

   // ****************************************************************
   // checks
   // ****************************************************************
   a_flame_off_idle: assert property (@(posedge clk) disable iff (!nrst)
      !heat_call && !history_recall ##1 !heat_call && !history_recall
      |=> !flame_led)
      else $error("flame led lit without heat call");
   a_pulse_selected: assert property (@(posedge clk) disable iff (!nrst)
      !heat_call && !ps_failed_open && !ps_failed_closed && !ps_opened_run
      |=> cur_pat_ff[1] == pat_pulse)
      else $error("standby pattern not pulse");
   a_heart_selected: assert property (@(posedge clk) disable iff (!nrst)
      heat_call && !ps_failed_open && !ps_failed_closed && !ps_opened_run
      |=> cur_pat_ff[1] == pat_heart)
      else $error("heat pattern not heartbeat");
   a_count_two: assert property (@(posedge clk) disable iff (!nrst)
      ps_failed_open |=> cur_x_ff[1] == `CNT_PS_OPEN)
      else $error("wrong open count");
   a_count_three: assert property (@(posedge clk) disable iff (!nrst)
      !ps_failed_open && ps_failed_closed
      |=> cur_x_ff[1] == `CNT_PS_CLOSED)
      else $error("wrong closed count");
   a_count_four: assert property (@(posedge clk) disable iff (!nrst)
      !ps_failed_open && !ps_failed_closed && ps_opened_run
      |=> cur_x_ff[1] == `CNT_PS_DROP)
      else $error("wrong drop count");
   a_restart_seq: assert property (@(posedge clk) disable iff (!nrst)
      sel_pat[1] != cur_pat_ff[1] |=> q_ff[1] == 8'h0)
      else $error("sequencer not restarted");
   a_rx_blink: assert property (@(posedge clk) disable iff (!nrst)
      bus_rx_ack && !bus_tx_active ##1 !bus_tx_active |=> bus_activity_led)
      else $error("no blink on receive");
   a_weak_clear: assert property (@(posedge clk) disable iff (!nrst)
      !heat_call |=> !weak_flame_flag)
      else $error("weak flame kept without heat call");
endmodule

// ---- verif/led_viewer.sv ----
`timescale 1ns/1ps
// ****************************************************************
// lamp viewer: reports each completed on or off run
// ****************************************************************
module led_viewer (
   // clock
   input wire logic clk,
   // observed lamp
   input wire logic led,
   // run report
   output logic done,
   output logic lvl,
   output logic [15:0] len
);
   logic prev_ff = 1'b0;
   logic [15:0] cnt_ff = 16'h0000;
   // a run ends when the lamp level changes
   always @(posedge clk) begin
      done <= (led !== prev_ff);
      lvl <= prev_ff;
      len <= cnt_ff;
      prev_ff <= led;
      cnt_ff <= (led !== prev_ff) ? 16'h0001 : cnt_ff + 16'h0001;
   end
endmodule

// ---- verif/status_led_pattern_generator_bench.sv ----
`timescale 1ns/1ps
module status_led_pattern_generator_bench;
   logic clk, nrst, heat_call, flame_present, flame_weak, normal_fire;
   logic flame_out_of_seq, history_recall, ps_failed_open;
   logic ps_failed_closed, ps_opened_run, bus_tx_active, bus_rx_ack;
   logic flame_led, status_led, bus_activity_led, weak_flame_flag;
   logic watched, done, lvl;
   logic [15:0] len;
   logic lv [32];
   logic [15:0] ln [32];
   int pick, err_total, checked, a, b, c;
   // ****************************************************************
   // clock, dut and viewer
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   assign watched = (pick == 0) ? flame_led :
                    (pick == 1) ? status_led : bus_activity_led;
   status_led_pattern_generator #(.TICK_CYCLES(4), .WEAK_CYCLES(20)) i_dut (
      .clk(clk), .nrst(nrst), .heat_call(heat_call),
      .flame_present(flame_present), .flame_weak(flame_weak),
      .normal_fire(normal_fire), .flame_out_of_seq(flame_out_of_seq),
      .history_recall(history_recall), .ps_failed_open(ps_failed_open),
      .ps_failed_closed(ps_failed_closed), .ps_opened_run(ps_opened_run),
      .bus_tx_active(bus_tx_active), .bus_rx_ack(bus_rx_ack),
      .flame_led(flame_led), .status_led(status_led),
      .bus_activity_led(bus_activity_led),
      .weak_flame_flag(weak_flame_flag));
   led_viewer i_view (.clk(clk), .led(watched), .done(done), .lvl(lvl),
      .len(len));
   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic results;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic grab(input int pk, input int n);
      int i, w;
      pick = pk;
      i = 0;
      w = 0;
      while (i < n && w < 5000) begin
         @(posedge clk);
         #1;
         if (done === 1'b1) begin
            lv[i] = lvl;
            ln[i] = len;
            i++;
         end
         w++;
      end
      if (i < n) begin
         err_total++;
         $display("CHECK FAILED runs expected %0d seen %0d", n, i);
         results();
      end
   endtask
   task automatic hilo(input logic [15:0] eh, input logic [15:0] el);
      int i;
      i = 2;
      while (i < 5 && lv[i] !== 1'b1) i++;
      chk("on run", eh, ln[i]);
      chk("off run", el, ln[i+1]);
   endtask
   // group sizes after the first long pause
   task automatic grp;
      int i, k;
      a = 0;
      b = 0;
      k = 0;
      i = 0;
      while (i < 24 && !(lv[i] === 1'b0 && ln[i] >= 40)) i++;
      for (i = i + 1; i < 24 && k < 2; i++) begin
         if (lv[i] === 1'b1) begin
            if (k == 0) a++;
            else b++;
         end else if (ln[i] >= 8) k++;
      end
   endtask
   task automatic ontime(input int pk, input int n);
      pick = pk;
      c = 0;
      repeat (n) begin
         @(posedge clk);
         #1;
         if (watched === 1'b1) c++;
      end
   endtask
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_standby;
      grab(1, 6);
      hilo(16'h0004, 16'h003C);
      ontime(0, 100);
      chk("flame dark", 16'h0000, c[15:0]);
      $display("test standby done");
   endtask
   task automatic t_heat;
      @(negedge clk);
      heat_call = 1'b1;
      flame_present = 1'b1;
      cyc(10);
      ontime(1, 64);
      chk("status heartbeat", 16'h0001, {15'h0000, c >= 16});
      ontime(0, 64);
      chk("flame heartbeat", 16'h0001, {15'h0000, c >= 16});
      $display("test heat done");
   endtask
   task automatic t_weak;
      @(negedge clk);
      flame_weak = 1'b1;
      normal_fire = 1'b1;
      cyc(10);
      chk("flag early", 16'h0000, {15'h0000, weak_flame_flag});
      cyc(20);
      chk("flag raised", 16'h0001, {15'h0000, weak_flame_flag});
      grab(0, 6);
      hilo(16'h0008, 16'h0008);
      @(negedge clk);
      history_recall = 1'b1;
      grab(0, 24);
      grp();
      chk("recall first", 16'h0001, a[15:0]);
      chk("recall second", 16'h0002, b[15:0]);
      @(negedge clk);
      history_recall = 1'b0;
      flame_weak = 1'b0;
      cyc(10);
      chk("flag held", 16'h0001, {15'h0000, weak_flame_flag});
      cyc(20);
      chk("flag cleared", 16'h0000, {15'h0000, weak_flame_flag});
      flame_weak = 1'b1;
      cyc(30);
      chk("flag again", 16'h0001, {15'h0000, weak_flame_flag});
      heat_call = 1'b0;
      cyc(3);
      chk("flag heat off", 16'h0000, {15'h0000, weak_flame_flag});
      flame_weak = 1'b0;
      normal_fire = 1'b0;
      $display("test weak flame done");
   endtask
   task automatic t_oos;
      @(negedge clk);
      heat_call = 1'b1;
      flame_out_of_seq = 1'b1;
      cyc(10);
      ontime(0, 64);
      chk("stray flame", 16'h0001, {15'h0000, c >= 16});
      @(negedge clk);
      flame_out_of_seq = 1'b0;
      $display("test stray flame done");
   endtask
   task automatic t_press;
      for (int k = 0; k < 3; k++) begin
         @(negedge clk);
         ps_failed_open = (k == 0);
         ps_failed_closed = (k == 1);
         ps_opened_run = (k == 2);
         grab(1, 24);
         grp();
         chk("fault count", 16'(k + 2), a[15:0]);
         chk("fault repeat", 16'(k + 2), b[15:0]);
      end
      @(negedge clk);
      ps_opened_run = 1'b0;
      heat_call = 1'b0;
      flame_present = 1'b0;
      $display("test pressure done");
   endtask
   task automatic t_bus;
      @(negedge clk);
      bus_rx_ack = 1'b1;
      @(negedge clk);
      bus_rx_ack = 1'b0;
      ontime(2, 20);
      chk("rx blink", 16'h0001, {15'h0000, c > 0 && c < 9});
      @(negedge clk);
      bus_tx_active = 1'b1;
      ontime(2, 40);
      chk("tx flashing", 16'h0014, c[15:0]);
      @(negedge clk);
      bus_tx_active = 1'b0;
      $display("test bus done");
   endtask
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      {heat_call, flame_present, flame_weak, normal_fire} = 4'h0;
      {flame_out_of_seq, history_recall, ps_failed_open} = 3'h0;
      {ps_failed_closed, ps_opened_run, bus_tx_active, bus_rx_ack} = 4'h0;
      nrst = 1'b0;
      pick = 0;
      err_total = 0;
      checked = 0;
      cyc(2);
      nrst = 1'b1;
      cyc(4);
      t_standby();
      t_heat();
      t_weak();
      t_oos();
      t_press();
      t_bus();
      results();
   end
endmodule
